// ### rtl/gpt_pkg.sv
// Shared constants, field layout and carriers of the general-purpose timer.
// Assumes a 32-bit AHB-Lite slave port decoded into a 256-byte window.
package gpt_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG        = 8'h00;
  localparam logic [7:0] OFS_CTL        = 8'h04;
  localparam logic [7:0] OFS_IMR        = 8'h08;
  localparam logic [7:0] OFS_RIS        = 8'h0C;
  localparam logic [7:0] OFS_MIS        = 8'h10;
  localparam logic [7:0] OFS_ICR        = 8'h14;
  localparam logic [7:0] OFS_LOAD_A     = 8'h20;
  localparam logic [7:0] OFS_MATCH_A    = 8'h24;
  localparam logic [7:0] OFS_PRE_A      = 8'h28;
  localparam logic [7:0] OFS_VALUE_A    = 8'h2C;
  localparam logic [7:0] OFS_CAPT_A     = 8'h30;
  localparam logic [7:0] OFS_LOAD_B     = 8'h40;
  localparam logic [7:0] OFS_MATCH_B    = 8'h44;
  localparam logic [7:0] OFS_PRE_B      = 8'h48;
  localparam logic [7:0] OFS_VALUE_B    = 8'h4C;
  localparam logic [7:0] OFS_CAPT_B     = 8'h50;
  localparam logic [7:0] OFS_LOAD_BOTH  = 8'h60;
  localparam logic [7:0] OFS_MATCH_BOTH = 8'h64;
  localparam logic [7:0] OFS_PRE_BOTH   = 8'h68;

  // Field positions
  localparam int CFG_TOP_LSB   = 0;
  localparam int CFG_MODE_LSB  = 4;
  localparam int CFG_MODE_STEP = 4;
  localparam int CFG_EDGE_LSB  = 12;
  localparam int CFG_W         = 16;
  localparam int CTL_EN_LSB    = 0;
  localparam int CTL_RTC_EN    = 2;
  localparam int CTL_W         = 3;
  localparam int IRQ_TIMEOUT   = 0;
  localparam int IRQ_CAP_MATCH = 1;
  localparam int IRQ_CAP_EVENT = 2;
  localparam int IRQ_RTC_MATCH = 3;
  localparam int IRQ_HALF_STEP = 8;
  localparam int IRQ_W         = 11;
  localparam int PRE_W         = 8;

  // Reset values
  localparam logic [CFG_W-1:0] CFG_RST   = 16'h0004;
  localparam logic [CTL_W-1:0] CTL_RST   = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST   = 11'h000;
  localparam logic [31:0]      LOAD_RST  = 32'hFFFF_FFFF;
  localparam logic [31:0]      MATCH_RST = 32'h0000_0000;
  localparam logic [PRE_W-1:0] PRE_RST   = 8'h00;
  localparam logic [31:0]      HALF_MASK = 32'h0000_FFFF;
  localparam logic [31:0]      FULL_MASK = 32'hFFFF_FFFF;

  // Bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    TOP_32_OS  = 3'h0,
    TOP_32_PER = 3'h1,
    TOP_32_RTC = 3'h2,
    TOP_PAIR   = 3'h4
  } top_cfg_type;

  typedef enum logic [2:0] {
    HM_ONE_SHOT  = 3'h0,
    HM_PERIODIC  = 3'h1,
    HM_CAP_COUNT = 3'h2,
    HM_CAP_TIME  = 3'h3,
    HM_PWM       = 3'h4,
    HM_RTC       = 3'h5
  } half_mode_type;

  localparam logic [1:0] EDGE_POS  = 2'h0;
  localparam logic [1:0] EDGE_NEG  = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  typedef struct packed {
    half_mode_type mode;
    logic [1:0]    edge_sel;
    logic          enable;
    logic          wide;
    logic          rtc_run;
  } half_ctl_type;

  typedef struct packed {
    logic [31:0]      load;
    logic [31:0]      match;
    logic [PRE_W-1:0] pre;
  } half_set_type;

  typedef struct packed {
    logic [31:0] value;
    logic [31:0] capture;
    logic        timeout;
    logic        cap_match;
    logic        cap_event;
    logic        rtc_match;
  } half_evt_type;

endpackage

// ### rtl/gpt_half.sv
// One timer half: prescaler, counter, capture and PWM logic.
// Assumes edge pulses already synchronised; settings from the register file.
`timescale 1ns/1ps
module gpt_half (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  srst_i,
  // Settings
  input  wire gpt_pkg::half_ctl_type ctl_i,
  input  wire gpt_pkg::half_set_type set_i,
  input  wire logic                  load_now_i,
  // Capture pin edges
  input  wire logic                  edge_rise_i,
  input  wire logic                  edge_fall_i,
  // Status
  output gpt_pkg::half_evt_type      stat_o,
  output logic                       pwm_o
);
  import gpt_pkg::*;

  logic [31:0]      cnt_ff;
  logic [31:0]      capt_ff;
  logic [PRE_W-1:0] pre_cnt_ff;
  logic             run_ff;
  logic             en_d_ff;
  logic             pwm_ff;
  logic [3:0]       evt_ff;
  logic [31:0]      width_mask;
  logic [31:0]      load_m;
  logic [31:0]      match_m;
  logic [31:0]      dec;
  logic             tick;
  logic             pin_evt;
  logic             start;
  logic             counting;
  logic             evt_to;
  logic             evt_cm;
  logic             evt_ce;
  logic             evt_rm;

  always_comb begin
    width_mask = ctl_i.wide ? FULL_MASK : HALF_MASK;
    load_m     = set_i.load & width_mask;
    match_m    = set_i.match & width_mask;
    dec        = (cnt_ff - 32'h0000_0001) & width_mask;
    tick       = ctl_i.wide | (pre_cnt_ff == PRE_RST); // R13
    pin_evt    = ((ctl_i.edge_sel == EDGE_POS) & edge_rise_i) |
                 ((ctl_i.edge_sel == EDGE_NEG) & edge_fall_i) |
                 ((ctl_i.edge_sel == EDGE_BOTH) & (edge_rise_i | edge_fall_i));
    start      = ctl_i.enable & ~en_d_ff;
    counting   = ctl_i.enable & run_ff & ~load_now_i & ~start;
    evt_to     = counting & tick & (cnt_ff == 32'h0000_0000) &
                 ((ctl_i.mode == HM_ONE_SHOT) | (ctl_i.mode == HM_PERIODIC)); // R18
    evt_cm     = counting & pin_evt & (ctl_i.mode == HM_CAP_COUNT) & (dec == match_m); // R10
    evt_ce     = counting & pin_evt & (ctl_i.mode == HM_CAP_TIME);
    evt_rm     = counting & (ctl_i.mode == HM_RTC) & ctl_i.rtc_run &
                 (cnt_ff == match_m); // R18
  end

  // Prescaler only divides in 16-bit use
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pre_cnt_ff <= PRE_RST;
    end else if (~ctl_i.enable | ctl_i.wide | tick) begin
      pre_cnt_ff <= set_i.pre; // R12 R13
    end else begin
      pre_cnt_ff <= pre_cnt_ff - 8'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      en_d_ff <= 1'b0;
      run_ff  <= 1'b0;
    end else begin
      en_d_ff <= ctl_i.enable;
      if (~ctl_i.enable) begin
        run_ff <= 1'b0;
      end else if (start) begin
        run_ff <= 1'b1;
      end else if (evt_to & (ctl_i.mode == HM_ONE_SHOT)) begin
        run_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_ff <= 32'h0000_0000;
    end else if (load_now_i | start) begin
      cnt_ff <= load_m; // R7
    end else if (counting) begin
      case (ctl_i.mode)
        HM_RTC: begin
          if (ctl_i.rtc_run) begin
            cnt_ff <= cnt_ff + 32'h0000_0001; // R14 R15
          end
        end
        HM_CAP_COUNT: begin
          if (pin_evt) begin
            cnt_ff <= evt_cm ? load_m : dec;
          end
        end
        HM_ONE_SHOT: begin
          if (tick & ~evt_to) begin
            cnt_ff <= dec;
          end
        end
        default: begin
          if (tick) begin
            cnt_ff <= (cnt_ff == 32'h0000_0000) ? load_m : dec;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      capt_ff <= 32'h0000_0000;
    end else if (evt_ce) begin
      capt_ff <= cnt_ff;
    end
  end

  // High above the match value, so the level flips as the count passes it
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pwm_ff <= 1'b0;
    end else begin
      pwm_ff <= ctl_i.enable & (ctl_i.mode == HM_PWM) & (cnt_ff > match_m); // R11
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      evt_ff <= 4'h0;
    end else begin
      evt_ff <= {evt_to, evt_cm, evt_ce, evt_rm};
    end
  end

  assign stat_o.value     = cnt_ff; // R16
  assign stat_o.capture   = capt_ff;
  assign stat_o.timeout   = evt_ff[3];
  assign stat_o.cap_match = evt_ff[2];
  assign stat_o.cap_event = evt_ff[1];
  assign stat_o.rtc_match = evt_ff[0];
  assign pwm_o            = pwm_ff;

endmodule

// ### rtl/gp_timer_irq_load_match_ctl.sv
// Timer register file, AHB-Lite slave, interrupt status and two halves.
// Assumes capture pins are asynchronous and hsel decodes a 256-byte window.
// Summary of operation
// (R1) Clearing sources drops exactly their pending state
// (R2) Handler must clear serviced source before return
// (R3) Clears may land late; set beats clear
// (R4) Per-source enable mask gates the request
// (R5) Seven sources: three per half, one RTC
// (R6) Raw and masked status readable, same layout
// (R7) Load write reloads running counter at once
// (R8) Programmed load value reads back per half
// (R9) Wide mode uses half A registers only
// (R10) Edge count reaching match raises capture match
// (R11) PWM output flips where counter meets match
// (R12) Eight-bit prescaler per half, readable
// (R13) Prescaler divides only in 16-bit use
// (R14) Clearing RTC enable stops RTC counting
// (R15) RTC enable acts only in RTC mode
// (R16) Live counter readable without disturbing it
// (R17) Settings writable to A, B or both
// (R18) Timeout at zero, RTC match on equality
// (R19) Wide one-shot/periodic/RTC or paired half modes
// (R20) Request is OR of masked status, level
// (R21) Status clear is write-one-to-clear
`timescale 1ns/1ps
module gp_timer_irq_load_match_ctl (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Capture pins and PWM outputs, index 0 is half A
  input  wire logic [1:0]  ccp_i,
  output logic [1:0]       pwm_o,
  // Interrupt request
  output logic             irq_o
);
  import gpt_pkg::*;

  logic [CFG_W-1:0] cfg_ff;
  logic [CTL_W-1:0] ctl_ff;
  logic [IRQ_W-1:0] imr_ff;
  logic [IRQ_W-1:0] raw_ff;
  logic [31:0]      load_ff  [2];
  logic [31:0]      match_ff [2];
  logic [PRE_W-1:0] pre_ff   [2];
  logic             wr_pend_ff;
  logic [7:0]       waddr_ff;
  logic [31:0]      hrdata_ff;
  logic             irq_ff;
  logic             hready_ff;
  logic             addr_take;
  logic             rd_take;
  logic             wr_cfg;
  logic             wr_ctl;
  logic             wr_imr;
  logic             wr_icr;
  logic [1:0]       wr_load;
  logic [1:0]       wr_match;
  logic [1:0]       wr_pre;
  logic [IRQ_W-1:0] set_bits;
  logic [IRQ_W-1:0] clr_mask;
  logic [31:0]      rd_data;
  logic             wide;
  top_cfg_type      top_cfg;
  half_ctl_type     hctl [2];
  half_evt_type     stat [2];

  assign top_cfg = top_cfg_type'(cfg_ff[CFG_TOP_LSB +: 3]);
  assign wide    = (top_cfg != TOP_PAIR); // R19

  assign addr_take = hsel_i & htrans_i[1] & hready_i;
  assign rd_take   = addr_take & ~hwrite_i;

  // Zero-wait slave; reads are prepared in the address phase
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_pend_ff <= 1'b0;
      waddr_ff   <= 8'h00;
      hready_ff  <= 1'b1;
    end else begin
      wr_pend_ff <= addr_take & hwrite_i & (hsize_i == HSIZE_WORD);
      waddr_ff   <= haddr_i[7:0];
      hready_ff  <= 1'b1;
    end
  end

  always_comb begin
    wr_cfg   = 1'b0;
    wr_ctl   = 1'b0;
    wr_imr   = 1'b0;
    wr_icr   = 1'b0;
    wr_load  = 2'b00;
    wr_match = 2'b00;
    wr_pre   = 2'b00;
    if (wr_pend_ff) begin
      if (waddr_ff == OFS_CFG) begin
        wr_cfg = 1'b1;
      end else if (waddr_ff == OFS_CTL) begin
        wr_ctl = 1'b1;
      end else if (waddr_ff == OFS_IMR) begin
        wr_imr = 1'b1;
      end else if (waddr_ff == OFS_ICR) begin
        wr_icr = 1'b1;
      end else if (waddr_ff == OFS_LOAD_A) begin
        wr_load = 2'b01;
      end else if (waddr_ff == OFS_LOAD_B) begin
        wr_load = 2'b10;
      end else if (waddr_ff == OFS_LOAD_BOTH) begin
        wr_load = 2'b11; // R17
      end else if (waddr_ff == OFS_MATCH_A) begin
        wr_match = 2'b01;
      end else if (waddr_ff == OFS_MATCH_B) begin
        wr_match = 2'b10;
      end else if (waddr_ff == OFS_MATCH_BOTH) begin
        wr_match = 2'b11; // R17
      end else if (waddr_ff == OFS_PRE_A) begin
        wr_pre = 2'b01;
      end else if (waddr_ff == OFS_PRE_B) begin
        wr_pre = 2'b10;
      end else if (waddr_ff == OFS_PRE_BOTH) begin
        wr_pre = 2'b11; // R17
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cfg_ff <= CFG_RST;
      ctl_ff <= CTL_RST;
      imr_ff <= IRQ_RST;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= hwdata_i[CFG_W-1:0];
      end
      if (wr_ctl) begin
        ctl_ff <= hwdata_i[CTL_W-1:0];
      end
      if (wr_imr) begin
        imr_ff <= hwdata_i[IRQ_W-1:0]; // R4
      end
    end
  end

  // Sticky status; a same-cycle event wins over the clear
  assign clr_mask = wr_icr ? hwdata_i[IRQ_W-1:0] : IRQ_RST;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      raw_ff <= IRQ_RST;
    end else begin
      raw_ff <= (raw_ff & ~clr_mask) | set_bits; // R1 R3 R21
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(raw_ff & imr_ff); // R4 R20
    end
  end

  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_half
      logic [2:0] sync_ff;
      logic [2:0] mode_f;

      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          load_ff[h]  <= LOAD_RST;
          match_ff[h] <= MATCH_RST;
          pre_ff[h]   <= PRE_RST;
        end else begin
          if (wr_load[h]) begin
            load_ff[h] <= hwdata_i; // R8
          end
          if (wr_match[h]) begin
            match_ff[h] <= hwdata_i;
          end
          if (wr_pre[h]) begin
            pre_ff[h] <= hwdata_i[PRE_W-1:0]; // R12
          end
        end
      end

      // Stage 0 feeds only stage 1; edges use stages 1 and 2
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          sync_ff <= 3'h0;
        end else begin
          sync_ff <= {sync_ff[1:0], ccp_i[h]};
        end
      end

      assign mode_f = cfg_ff[CFG_MODE_LSB + h*CFG_MODE_STEP +: 3];

      always_comb begin
        hctl[h].edge_sel = cfg_ff[CFG_EDGE_LSB + 2*h +: 2];
        hctl[h].wide     = wide & (h == 0);
        hctl[h].enable   = ctl_ff[CTL_EN_LSB + h] & ((h == 0) | ~wide); // R9
        if (h == 0 && wide) begin
          case (top_cfg)
            TOP_32_PER: hctl[h].mode = HM_PERIODIC;
            TOP_32_RTC: hctl[h].mode = HM_RTC;
            default:    hctl[h].mode = HM_ONE_SHOT;
          endcase
        end else if (mode_f > 3'(HM_PWM)) begin
          hctl[h].mode = HM_ONE_SHOT;
        end else begin
          hctl[h].mode = half_mode_type'(mode_f);
        end
        hctl[h].rtc_run = ctl_ff[CTL_RTC_EN] & (hctl[h].mode == HM_RTC); // R15
      end

      gpt_half u_half (
        .mclk_i      (mclk_i),
        .srst_i      (srst_i),
        .ctl_i       (hctl[h]),
        // New load word must reach the counter in its own write cycle
        .set_i       ({wr_load[h] ? hwdata_i : load_ff[h], match_ff[h], pre_ff[h]}), // R7
        .load_now_i  (wr_load[h]),
        .edge_rise_i (sync_ff[1] & ~sync_ff[2]),
        .edge_fall_i (~sync_ff[1] & sync_ff[2]),
        .stat_o      (stat[h]),
        .pwm_o       (pwm_o[h])
      );

      assign set_bits[IRQ_HALF_STEP*h + IRQ_TIMEOUT]   = stat[h].timeout; // R5
      assign set_bits[IRQ_HALF_STEP*h + IRQ_CAP_MATCH] = stat[h].cap_match;
      assign set_bits[IRQ_HALF_STEP*h + IRQ_CAP_EVENT] = stat[h].cap_event;
    end
  endgenerate

  assign set_bits[IRQ_RTC_MATCH] = stat[0].rtc_match | stat[1].rtc_match;
  assign set_bits[IRQ_HALF_STEP-1:IRQ_RTC_MATCH+1] = '0;

  always_comb begin
    rd_data = 32'h0000_0000;
    if (haddr_i[7:0] == OFS_CFG) begin
      rd_data = {16'h0000, cfg_ff};
    end else if (haddr_i[7:0] == OFS_CTL) begin
      rd_data = {29'h0, ctl_ff};
    end else if (haddr_i[7:0] == OFS_IMR) begin
      rd_data = {21'h0, imr_ff};
    end else if (haddr_i[7:0] == OFS_RIS) begin
      rd_data = {21'h0, raw_ff}; // R6
    end else if (haddr_i[7:0] == OFS_MIS) begin
      rd_data = {21'h0, raw_ff & imr_ff}; // R6
    end else if (haddr_i[7:0] == OFS_LOAD_A) begin
      rd_data = load_ff[0]; // R8
    end else if (haddr_i[7:0] == OFS_LOAD_B) begin
      rd_data = load_ff[1];
    end else if (haddr_i[7:0] == OFS_MATCH_A) begin
      rd_data = match_ff[0];
    end else if (haddr_i[7:0] == OFS_MATCH_B) begin
      rd_data = match_ff[1];
    end else if (haddr_i[7:0] == OFS_PRE_A) begin
      rd_data = {24'h0, pre_ff[0]}; // R12
    end else if (haddr_i[7:0] == OFS_PRE_B) begin
      rd_data = {24'h0, pre_ff[1]};
    end else if (haddr_i[7:0] == OFS_VALUE_A) begin
      rd_data = stat[0].value; // R16
    end else if (haddr_i[7:0] == OFS_VALUE_B) begin
      rd_data = stat[1].value;
    end else if (haddr_i[7:0] == OFS_CAPT_A) begin
      rd_data = stat[0].capture;
    end else if (haddr_i[7:0] == OFS_CAPT_B) begin
      rd_data = stat[1].capture;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_ff <= rd_data;
    end
  end

  assign hreadyout_o = hready_ff;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_ff;
  assign irq_o       = irq_ff;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  property p_clear_drops;
    (|clr_mask) |=> ((raw_ff & $past(clr_mask & ~set_bits)) == '0);
  endproperty
  a_clear_drops: assert property (p_clear_drops) // R1
    else $error("cleared status bit still pending");

  property p_clear_keeps;
    wr_icr |=> ((raw_ff & $past(raw_ff & ~clr_mask)) == $past(raw_ff & ~clr_mask));
  endproperty
  a_clear_keeps: assert property (p_clear_keeps) // R21
    else $error("zero in clear word disturbed a status bit");

  property p_set_wins;
    (|set_bits) |=> ((raw_ff & $past(set_bits)) == $past(set_bits));
  endproperty
  a_set_wins: assert property (p_set_wins) // R3
    else $error("event lost against clear");

  property p_mask_blocks;
    ((raw_ff & imr_ff) == '0) [*2] |-> !irq_o;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) // R4
    else $error("request without enabled pending source");

  property p_irq_follows;
    (|(raw_ff & imr_ff)) |=> irq_o;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // R20
    else $error("request missing for enabled pending source");

  property p_masked_read;
    (rd_take && haddr_i[7:0] == OFS_MIS) |=> hrdata_o == {21'h0, $past(raw_ff & imr_ff)};
  endproperty
  a_masked_read: assert property (p_masked_read) // R6
    else $error("masked status read wrong");

  property p_load_now;
    wr_load[0] |=> stat[0].value == ($past(hwdata_i) & (wide ? FULL_MASK : HALF_MASK));
  endproperty
  a_load_now: assert property (p_load_now) // R7
    else $error("load write not in counter next cycle");

  property p_load_read;
    (rd_take && haddr_i[7:0] == OFS_LOAD_A) |=> hrdata_o == $past(load_ff[0]);
  endproperty
  a_load_read: assert property (p_load_read) // R8
    else $error("load readback wrong");

  property p_pre_read;
    wr_pre[1] ##1 (rd_take && haddr_i[7:0] == OFS_PRE_B)
      |=> hrdata_o == {24'h0, $past(hwdata_i[7:0], 2)};
  endproperty
  a_pre_read: assert property (p_pre_read) // R12
    else $error("prescale readback wrong");

  property p_rtc_stop;
    (hctl[0].mode == HM_RTC && !ctl_ff[CTL_RTC_EN] && !wr_load[0]) [*2]
      |-> $stable(stat[0].value);
  endproperty
  a_rtc_stop: assert property (p_rtc_stop) // R14
    else $error("RTC counted while disabled");

  property p_value_read;
    (rd_take && haddr_i[7:0] == OFS_VALUE_A) |=> hrdata_o == $past(stat[0].value);
  endproperty
  a_value_read: assert property (p_value_read) // R16
    else $error("live value read wrong");

  c_irq: cover property (!irq_o ##1 irq_o);
  c_rtc_match: cover property (stat[0].rtc_match);
  c_cap_match: cover property (stat[1].cap_match);
  c_pwm_rise: cover property (!pwm_o[0] ##1 pwm_o[0]);

endmodule

// ### test/gpt_host_model.sv
// Bus master standing in for the processor that drives the timer registers.
// Assumes one slave whose hreadyout is fed back as hready_i.
`timescale 1ns/1ps
module gpt_host_model (
  // Clock and bus answer
  input  wire logic        mclk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  // Bus request
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  import gpt_pkg::*;

  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = HSIZE_WORD;
    hwdata_o = 32'h0;
  end

  // One single word transfer; call right after a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    hsel_o   <= 1'b1;
    htrans_o <= 2'h2;
    haddr_o  <= {24'h0, a};
    hwrite_o <= w;
    hsize_o  <= HSIZE_WORD;
    @(posedge mclk_i);
    while (hready_i !== 1'b1) @(posedge mclk_i);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    @(posedge mclk_i);
    while (hready_i !== 1'b1) @(posedge mclk_i);
    q = hrdata_i;
    // Stale data must not look valid once released
    hwdata_o <= ~d;
  endtask
endmodule

// ### test/test_gp_timer_irq_load_match_ctl.sv
// Self-checking bench: register access, interrupts, load, prescale, RTC.
// Assumes the host model as bus master; capture pins held low except pin B, pulsed in the capture test.
`timescale 1ns/1ps
module test_gp_timer_irq_load_match_ctl;
  import gpt_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, v1, v2;
  logic [1:0]  htrans, pwm;
  logic [2:0]  hsize;
  logic [1:0]  ccp = 2'h0;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 mclk_i = ~mclk_i;

  gp_timer_irq_load_match_ctl i_dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .ccp_i(ccp), .pwm_o(pwm), .irq_o(irq));

  gpt_host_model i_host (
    .mclk_i(mclk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.bus(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    i_host.bus(a, 1'b0, 32'h0, q);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    check(name, exp, q);
  endtask

  task automatic t_reset;
    rd_chk("cfg", OFS_CFG, {16'h0000, CFG_RST});
    rd_chk("load_a", OFS_LOAD_A, LOAD_RST);
    rd_chk("imr", OFS_IMR, 32'h0);
    rd_chk("ris", OFS_RIS, 32'h0);
    rd_chk("unmapped", 8'h7C, 32'h0);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic t_settings;
    wr(OFS_PRE_BOTH, 32'h0000_00FF);
    rd_chk("pre_a", OFS_PRE_A, 32'h0000_00FF);
    wr(OFS_PRE_A, 32'h0);
    rd_chk("pre_b", OFS_PRE_B, 32'h0000_00FF);
    wr(OFS_PRE_B, 32'h0);
    rd_chk("pre_b zero", OFS_PRE_B, 32'h0);
    wr(OFS_LOAD_B, 32'h0000_1234);
    rd_chk("load_b", OFS_LOAD_B, 32'h0000_1234);
    rd_chk("load_a kept", OFS_LOAD_A, LOAD_RST);
    wr(OFS_MATCH_BOTH, 32'h0000_0055);
    rd_chk("match_a", OFS_MATCH_A, 32'h0000_0055);
    rd_chk("match_b", OFS_MATCH_B, 32'h0000_0055);
  endtask

  // Handler clears early, not as its last action
  task automatic t_timeout;
    wr(OFS_LOAD_A, 32'h0000_0008);
    wr(OFS_CTL, 32'h1);
    repeat (30) @(posedge mclk_i);
    rd_chk("ris timeout", OFS_RIS, 32'h1);
    rd_chk("mis masked", OFS_MIS, 32'h0);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_IMR, 32'h1);
    repeat (3) @(posedge mclk_i);
    check("irq", 32'h1, {31'h0, irq});
    wr(OFS_ICR, 32'h0);
    rd_chk("ris zero write", OFS_RIS, 32'h1);
    wr(OFS_ICR, 32'h1);
    rd_chk("mis", OFS_MIS, 32'h0);
    repeat (3) @(posedge mclk_i);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(OFS_IMR, 32'h0);
    wr(OFS_CTL, 32'h0);
  endtask

  task automatic t_load;
    wr(OFS_CFG, 32'h0000_0014);
    wr(OFS_PRE_A, 32'h0000_0009);
    wr(OFS_LOAD_A, 32'h0000_4000);
    wr(OFS_CTL, 32'h1);
    rd(OFS_VALUE_A, v1);
    rd(OFS_VALUE_A, v2);
    check("slow count", 32'h1, {31'h0, v2 <= v1 && v1 - v2 <= 1});
    wr(OFS_LOAD_A, 32'h0000_2000);
    rd(OFS_VALUE_A, v1);
    check("reload", 32'h1, {31'h0, v1 <= 32'h2000 && v1 >= 32'h1FFE});
    wr(OFS_CTL, 32'h0);
    wr(OFS_PRE_A, 32'h0);
  endtask

  task automatic t_rtc;
    wr(OFS_CFG, 32'h0000_0004);
    // One-shot keeps counting down with the RTC enable set
    wr(OFS_CTL, 32'h5);
    repeat (2) @(posedge mclk_i);
    rd(OFS_VALUE_A, v1);
    repeat (10) @(posedge mclk_i);
    rd(OFS_VALUE_A, v2);
    check("rtc idle", 32'h0000_000C, v1 - v2);
    wr(OFS_CFG, 32'h0000_0002);
    wr(OFS_LOAD_A, 32'h0);
    wr(OFS_MATCH_A, 32'h0000_0030);
    repeat (60) @(posedge mclk_i);
    rd(OFS_RIS, v1);
    check("rtc match", 32'h1, {31'h0, v1[IRQ_RTC_MATCH]});
    wr(OFS_CTL, 32'h1);
    rd(OFS_VALUE_A, v1);
    repeat (5) @(posedge mclk_i);
    rd(OFS_VALUE_A, v2);
    check("rtc stop", v1, v2);
    wr(OFS_CTL, 32'h0);
  endtask

  // Two rises on pin B count 3 down to match 1; PWM high 16 of 33 cycles
  task automatic t_capture_pwm;
    int hi;
    hi = 0;
    wr(OFS_LOAD_A, 32'h0000_0020);
    wr(OFS_MATCH_A, 32'h0000_0010);
    wr(OFS_LOAD_B, 32'h0000_0003);
    wr(OFS_MATCH_B, 32'h0000_0001);
    wr(OFS_CFG, 32'h0000_0244);
    wr(OFS_CTL, 32'h3);
    repeat (2) begin
      ccp <= 2'h2;
      repeat (4) @(posedge mclk_i);
      ccp <= 2'h0;
      repeat (4) @(posedge mclk_i);
    end
    rd(OFS_RIS, v1);
    check("cap match", 32'h1, {31'h0, v1[IRQ_HALF_STEP + IRQ_CAP_MATCH]});
    repeat (66) begin
      @(posedge mclk_i);
      hi += pwm[0];
    end
    check("pwm high", 32'h0000_0020, hi);
    wr(OFS_CTL, 32'h0);
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    t_reset();
    t_settings();
    t_timeout();
    t_load();
    t_rtc();
    t_capture_pwm();
    wrap_up();
  end
endmodule
